// File: dv/address_translation_unit_bench.sv
// Testbench of the address translation unit: APB set-up, both translators, walks.
// Assumes the memory model answers each walker access after a short random wait.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h got %h", nm, e, g); end end
module address_translation_unit_bench;
  import atu_pkg::*;
  localparam logic [31:0] ORG = 32'h0010_0000;
  localparam logic [8:0] MASK = 9'h001;
  localparam logic [23:0] VSID = 24'h01_2345;
  localparam logic [19:0] RPN = 20'hC0DE5;
  localparam logic [31:0] EA1 = 32'h5ABC_D678;
  localparam logic [31:0] EA2 = 32'h5000_3ABC;
  logic ref_clk, reset, ce, psel, penable, pwrite, pready, pslverr, er;
  logic ivalid, dvalid, idone, ddone, mem_req, mem_ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, rd, r, pa1, pa2;
  logic [1:0] mem_lat;
  xreq_t ireq, dreq;
  xresp_t iresp, dresp;
  mreq_t mem;
  logic [32:0] iq[$];
  logic [32:0] dq[$];
  logic [31:0] seed = 32'hC6D7;
  int err_total = 0;
  int n_checks = 0;
  int na;
  address_translation_unit u_address_translation_unit (.I_REF_CLK(ref_clk), .I_RESET(reset), .I_CE(ce),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_IVALID(ivalid), .I_IREQ(ireq),
    .O_IDONE(idone), .O_IRESP(iresp), .I_DVALID(dvalid), .I_DREQ(dreq), .O_DDONE(ddone), .O_DRESP(dresp),
    .O_MEM_REQ(mem_req), .O_MEM(mem), .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata));
  atu_mem_model u_atu_mem_model (.i_clk(ref_clk), .i_reset(reset), .i_req(mem_req), .i_mem(mem),
    .i_lat(mem_lat), .o_ack(mem_ack), .o_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, random source and table address helper
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  function automatic logic [31:0] pteg(input logic [31:0] ea, input bit sec);
    logic [18:0] h;
    h = VSID[18:0] ^ {3'h0, ea[27:12]};
    if (sec) h = ~h;
    return {ORG[31:25], ORG[24:16] | (h[18:10] & MASK), h[9:0], 6'h00};
  endfunction : pteg
  ////////////////////////////////////////////////////////////////////////////
  // Bus and request tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("apb read", e, rd)
  endtask : rdchk
  task automatic treq(input bit d, input logic [31:0] ea, input logic usr, input logic st, input logic [32:0] e);
    int a0, k;
    logic [31:0] x;
    @(posedge ref_clk);
    a0 = u_atu_mem_model.n_acc;
    x = rnd();
    mem_lat <= x[1:0];
    if (d) begin dq.push_back(e); dvalid <= 1'b1; dreq <= '{ea, usr, st}; end
    else begin iq.push_back(e); ivalid <= 1'b1; ireq <= '{ea, usr, st}; end
    k = 0;
    do begin @(posedge ref_clk); k++; end while ((d ? ddone : idone) !== 1'b1 && k < 2000);
    `CHK("done wait", 1'b1, k < 2000)
    dvalid <= 1'b0;
    ivalid <= 1'b0;
    na = u_atu_mem_model.n_acc - a0;
  endtask : treq
  task automatic cmp(input string nm, input logic [32:0] e, input xresp_t g);
    `CHK(nm, e[32], g.fault)
    if (e[32] === 1'b0) begin
      `CHK(nm, e[31:0], g.pa)
      `CHK(nm, e[11:5], g.cset)
    end
  endtask : cmp
  task automatic test_done();
    `CHK("queue left", 0, dq.size() + iq.size())
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: oldest note against each done pulse
  always @(posedge ref_clk) begin
    if (ddone === 1'b1 && dq.size() > 0) cmp("dresp", dq.pop_front(), dresp);
    if (idone === 1'b1 && iq.size() > 0) cmp("iresp", iq.pop_front(), iresp);
  end
  initial begin
    #(50000 * 10);
    err_total++;
    $display("ERROR watchdog expected finish got hang");
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ivalid = 1'b0; dvalid = 1'b0; ireq = '0; dreq = '0; mem_lat = 2'h0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_PTB, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      treq(i[0], r, r[0], r[1], {1'b0, r});
      `CHK("real mode accesses", 0, na)
    end
    $display("test real mode done");
    wr(OFF_PTB, {ORG[31:16], 7'h00, MASK});
    wr(8'h54, {8'h00, VSID});
    wr(8'h58, {8'h10, VSID});
    wr(8'hC0, 32'hA000_0003);
    wr(8'hC4, 32'h3000_0002);
    wr(8'hC8, 32'hB000_0003);
    wr(8'hCC, 32'h4000_0001);
    rdchk(8'h58, {8'h10, VSID});
    pa1 = pteg(EA1, 1'b0) + 32'd28;
    pa2 = pteg(EA2, 1'b1) + 32'd4;
    u_atu_mem_model.mem[pa1 - 32'd4] = {1'b1, VSID, 1'b0, EA1[27:22]};
    u_atu_mem_model.mem[pa1] = {RPN, 12'h002};
    u_atu_mem_model.mem[pa2 - 32'd4] = {1'b1, VSID, 1'b1, EA2[27:22]};
    u_atu_mem_model.mem[pa2] = {20'h0BEEF, 12'h002};
    wr(OFF_CTRL, 32'h2);
    treq(0, 32'h5ABC_D000, 1'b0, 1'b0, {1'b0, 32'h5ABC_D000});
    treq(1, EA1, 1'b0, 1'b0, {1'b0, RPN, EA1[11:0]});
    `CHK("primary walk", 6, na)
    `CHK("ref bit", {RPN, 12'h102}, u_atu_mem_model.mem[pa1])
    treq(1, EA1, 1'b0, 1'b0, {1'b0, RPN, EA1[11:0]});
    `CHK("cache hit", 0, na)
    treq(1, EA1, 1'b0, 1'b1, {1'b0, RPN, EA1[11:0]});
    `CHK("chg bit", {RPN, 12'h182}, u_atu_mem_model.mem[pa1])
    treq(1, EA1, 1'b0, 1'b1, {1'b0, RPN, EA1[11:0]});
    `CHK("store hit", 0, na)
    wr(OFF_INVAL, EA1);
    treq(1, EA1, 1'b0, 1'b0, {1'b0, RPN, EA1[11:0]});
    `CHK("inval refill", 1'b1, na > 0)
    wr(OFF_SYNC, 32'h0);
    rdchk(OFF_STAT, 32'h0);
    treq(1, EA2, 1'b0, 1'b0, {1'b0, 20'h0BEEF, EA2[11:0]});
    `CHK("secondary walk", 11, na)
    $display("test page walk done");
    treq(1, 32'hA001_2344, 1'b1, 1'b0, {1'b0, 32'h3001_2344});
    `CHK("block no walk", 0, na)
    treq(1, 32'hA002_0000, 1'b0, 1'b0, {1'b1, 32'h0});
    `CHK("failed search", 16, na)
    treq(1, 32'hB000_0010, 1'b0, 1'b0, {1'b0, 32'h4000_0010});
    treq(1, 32'hB000_0010, 1'b0, 1'b1, {1'b1, 32'h0});
    $display("test block done");
    wr(OFF_CTRL, 32'h3);
    treq(0, 32'h5ABC_D000, 1'b0, 1'b0, {1'b0, RPN, 12'h000});
    treq(0, 32'h6ABC_D000, 1'b0, 1'b0, {1'b1, 32'h0});
    treq(1, 32'h6ABC_D100, 1'b0, 1'b0, {1'b0, RPN, 12'h100});
    $display("test instruction side done");
    @(posedge ref_clk);
    ce <= 1'b0;
    @(posedge ref_clk);
    `CHK("freeze ready", 1'b0, pready)
    ce <= 1'b1;
    $display("test clock enable done");
    repeat (3) @(posedge ref_clk);
    test_done();
  end
endmodule : address_translation_unit_bench
`default_nettype wire

// File: dv/atu_mem_model.sv
// Memory model behind the table walker of the address translation unit.
// Assumes a level request held until ack; wait before each ack set by i_lat.
`timescale 1ns/10ps
`default_nettype none
module atu_mem_model
  import atu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,
  input wire atu_pkg::mreq_t i_mem,
  input wire logic [1:0] i_lat,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [logic [31:0]];
  int n_acc;
  int wait_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // One access per ack; data line toggles while no answer is given
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h5A5A_A5A5;
      wait_cnt <= 0;
      n_acc <= 0;
    end else if (i_req && !o_ack && wait_cnt >= i_lat) begin
      o_ack <= 1'b1;
      wait_cnt <= 0;
      n_acc <= n_acc + 1;
      if (i_mem.we) mem[i_mem.addr] = i_mem.wdata;
      o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : 32'h0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : atu_mem_model
`default_nettype wire

// File: rtl/address_translation_unit.sv
// Instruction and data address translators with shared table walker.
// Assumes requests held until done and a memory port that acks each access.
// What this block does
// - 4-KB pages inside 256-MB segments
// - Block regions 128 KB to 256 MB
// - Translation off gives physical equals effective
// - Eight instruction and eight data block entries
// - Segment id replaces top four address bits
// - Per-side 64x2 translation cache with LRU
// - Look up translation cache first
// - Hashed hardware table search on miss
// - Found entry loaded into missing side's cache
// - Hardware maintains referenced and changed bits
// - Entry invalidate and synchronize supported
// - Table size set by base register mask
// - Two identical segment register copies
// - Page swaps bits above 4 KB offset
// - Access carries side, privilege, load/store
// - No-execute segments refuse instruction fetch
// - User/supervisor, read-only, guarded enforced
// - Physical set index and page tag outputs
// - Physical address handed to cache path
// - Each side translates only when enabled
// - Block hit overrides parallel page result
// - Search sets referenced, store sets both
// - Store hit with clear changed bit updates
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module address_translation_unit (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_IVALID,
  input wire atu_pkg::xreq_t I_IREQ,
  output logic O_IDONE,
  output atu_pkg::xresp_t O_IRESP,
  input wire logic I_DVALID,
  input wire atu_pkg::xreq_t I_DREQ,
  output logic O_DDONE,
  output atu_pkg::xresp_t O_DRESP,
  output logic O_MEM_REQ,
  output atu_pkg::mreq_t O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA
);
  import atu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register file
  logic [1:0] ctrl_reg;
  logic [31:0] ptb_reg, rd_mux;
  logic sync_reg, apb_wr, mapped, inval, sync_set;
  seg_t seg_copy [2][SEG_N];
  logic [31:0] bat_u [2][BAT_N], bat_l [2][BAT_N];
  seg_t seg_wr;
  walk_st_t w_st;

  assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
  assign mapped = (I_PADDR[1:0] == 2'h0) && (I_PADDR[7:6] != 2'h0 || I_PADDR <= OFF_SYNC);
  assign O_PREADY = I_CE;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
  assign inval = apb_wr && I_PADDR == OFF_INVAL;
  assign sync_set = apb_wr && I_PADDR == OFF_SYNC;
  assign seg_wr = {I_PWDATA[SEG_NX], I_PWDATA[SEG_KS], I_PWDATA[SEG_KP], I_PWDATA[23:0]};

  always_comb begin
    rd_mux = 32'h0;
    unique case (I_PADDR[7:6])
      2'h0: begin
        if (I_PADDR == OFF_CTRL) rd_mux[1:0] = ctrl_reg;
        if (I_PADDR == OFF_STAT) rd_mux[1:0] = {sync_reg, w_st != W_IDLE};
        if (I_PADDR == OFF_PTB) rd_mux = ptb_reg;
      end
      REGION_SEG: begin
        rd_mux[23:0] = seg_copy[0][I_PADDR[5:2]].vsid;
        rd_mux[SEG_NX] = seg_copy[0][I_PADDR[5:2]].nx;
        rd_mux[SEG_KP] = seg_copy[0][I_PADDR[5:2]].kp;
        rd_mux[SEG_KS] = seg_copy[0][I_PADDR[5:2]].ks;
      end
      default: rd_mux = I_PADDR[2] ? bat_l[I_PADDR[6]][I_PADDR[5:3]] : bat_u[I_PADDR[6]][I_PADDR[5:3]];
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_PRDATA <= 32'h0;
    end else if (I_CE && I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      ctrl_reg <= CTRL_RST;
      ptb_reg <= PTB_RST;
    end else if (apb_wr && I_PADDR == OFF_CTRL) begin
      ctrl_reg <= I_PWDATA[1:0];
    end else if (apb_wr && I_PADDR == OFF_PTB) begin
      ptb_reg <= I_PWDATA;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      seg_copy <= '{default: '0};
    end else if (apb_wr && I_PADDR[7:6] == REGION_SEG) begin
      seg_copy[0][I_PADDR[5:2]] <= seg_wr;
      seg_copy[1][I_PADDR[5:2]] <= seg_wr;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      bat_u <= '{default: 32'h0};
      bat_l <= '{default: 32'h0};
    end else if (apb_wr && I_PADDR[7]) begin
      if (I_PADDR[2]) begin
        bat_l[I_PADDR[6]][I_PADDR[5:3]] <= I_PWDATA;
      end else begin
        bat_u[I_PADDR[6]][I_PADDR[5:3]] <= I_PWDATA;
      end
    end
  end

  // Synchronize completes once no table search is in flight
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      sync_reg <= 1'b0;
    end else if (sync_set) begin
      sync_reg <= 1'b1;
    end else if (I_CE && w_st == W_IDLE) begin
      sync_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table walker, shared by both sides
  xreq_t req [2];
  wire [1:0] walk_req;
  logic w_side, w_store, w_sec, w_fault, match, need_upd;
  logic [2:0] w_idx;
  logic [31:0] w_ea, w_w1;
  logic [23:0] w_vsid;
  logic [18:0] hash;
  logic [25:0] pteg;

  assign req[0] = '{ea: I_IREQ.ea, user: I_IREQ.user, store: 1'b0};
  assign req[1] = I_DREQ;
  assign hash = (w_vsid[18:0] ^ {3'h0, w_ea[27:12]}) ^ {19{w_sec}};
  assign pteg = {ptb_reg[31:25], ptb_reg[24:16] | (hash[18:10] & ptb_reg[8:0]), hash[9:0]};
  assign match = I_MEM_RDATA[PTE_V] && I_MEM_RDATA[30:7] == w_vsid
    && I_MEM_RDATA[PTE_H] == w_sec && I_MEM_RDATA[5:0] == w_ea[27:22];
  assign need_upd = w_store ? !(I_MEM_RDATA[PTE_R] && I_MEM_RDATA[PTE_C]) : !I_MEM_RDATA[PTE_R];
  assign O_MEM_REQ = w_st == W_RD0 || w_st == W_RD1 || w_st == W_UPD;
  assign O_MEM = '{addr: {pteg, w_idx, w_st != W_RD0, 2'h0}, we: w_st == W_UPD, wdata: w_w1};

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      w_st <= W_IDLE;
      w_side <= 1'b0;
      w_store <= 1'b0;
      w_sec <= 1'b0;
      w_fault <= 1'b0;
      w_idx <= 3'h0;
      w_ea <= 32'h0;
      w_w1 <= 32'h0;
      w_vsid <= 24'h0;
    end else if (I_CE) begin
      unique case (w_st)
        W_IDLE: if (|walk_req) begin
          w_side <= walk_req[1];
          w_ea <= req[walk_req[1]].ea;
          w_store <= req[walk_req[1]].store;
          w_vsid <= seg_copy[walk_req[1]][req[walk_req[1]].ea[31:28]].vsid;
          w_sec <= 1'b0;
          w_idx <= 3'h0;
          w_fault <= 1'b0;
          w_st <= W_RD0;
        end
        W_RD0: if (I_MEM_ACK) begin
          if (match) begin
            w_st <= W_RD1;
          end else if (w_idx != 3'h7) begin
            w_idx <= w_idx + 3'h1;
          end else if (!w_sec) begin
            w_sec <= 1'b1;
            w_idx <= 3'h0;
          end else begin
            w_fault <= 1'b1;
            w_st <= W_DONE;
          end
        end
        W_RD1: if (I_MEM_ACK) begin
          w_w1 <= I_MEM_RDATA | PTE_R_MASK | (w_store ? PTE_C_MASK : 32'h0);
          w_st <= need_upd ? W_UPD : W_DONE;
        end
        W_UPD: if (I_MEM_ACK) w_st <= W_DONE;
        W_DONE: w_st <= W_IDLE;
        default: w_st <= W_IDLE;
      endcase
    end
  end

  function automatic logic perm_ok(input logic key, input logic [1:0] pp, input logic st);
    perm_ok = key ? (pp != 2'h0) && !(st && pp != 2'h2) : !(st && pp == 2'h3);
  endfunction : perm_ok

  ////////////////////////////////////////////////////////////////////////
  // Per-side lookup, translation cache and request sequencing
  for (genvar s = 0; s < 2; s++) begin : g_side
    side_st_t st_reg;
    xresp_t resp_reg;
    tlb_ent_t tlb [TLB_SETS][TLB_WAYS];
    tlb_ent_t te;
    logic [1:0] wh, tv [TLB_SETS];
    logic [TLB_SETS-1:0] lru_reg;
    seg_t sg;
    logic [5:0] set, fset;
    logic [33:0] tag, ftag;
    logic bhit, bok, need_walk, fin, flt, fway, fill;
    logic [14:0] bmask;
    logic [31:0] bpa, pa;

    assign walk_req[s] = st_reg == S_WALK;
    assign fset = w_ea[17:12];
    assign ftag = {w_vsid, w_ea[27:18]};
    assign fill = w_st == W_DONE && !w_fault && w_side == 1'(s);
    assign fway = (tv[fset][0] && tlb[fset][0].tag == ftag) ? 1'b0
      : (tv[fset][1] && tlb[fset][1].tag == ftag) ? 1'b1 : lru_reg[fset];

    always_comb begin
      sg = seg_copy[s][req[s].ea[31:28]];
      set = req[s].ea[17:12];
      tag = {sg.vsid, req[s].ea[27:18]};
      for (int j = 0; j < TLB_WAYS; j++) begin
        wh[j] = tv[set][j] && tlb[set][j].tag == tag;
      end
      te = wh[1] ? tlb[set][1] : tlb[set][0];
      bhit = 1'b0;
      bok = 1'b0;
      bpa = 32'h0;
      bmask = 15'h0;
      for (int j = BAT_N - 1; j >= 0; j--) begin
        bmask = {4'h0, bat_u[s][j][BAT_BL_LSB +: 11]};
        if ((req[s].user ? bat_u[s][j][BAT_VP] : bat_u[s][j][BAT_VS])
            && ((req[s].ea[31:17] ^ bat_u[s][j][31:17]) & ~bmask) == 15'h0) begin
          bhit = 1'b1;
          bpa = {bat_l[s][j][31:17] | (req[s].ea[31:17] & bmask), req[s].ea[16:0]};
          bok = perm_ok(1'b1, bat_l[s][j][1:0], req[s].store)
            && !(s == 0 && bat_l[s][j][BAT_WIMG_LSB]);
        end
      end
      need_walk = !(|wh) || (req[s].store && !te.c);
      fin = 1'b1;
      flt = 1'b0;
      pa = req[s].ea;
      if (!en_bit(s)) begin
        pa = req[s].ea;
      end else if (bhit) begin
        pa = bpa;
        flt = !bok;
      end else if (s == 0 && sg.nx) begin
        flt = 1'b1;
      end else if (!need_walk) begin
        pa = {te.rpn, req[s].ea[11:0]};
        flt = !perm_ok(req[s].user ? sg.kp : sg.ks, te.pp, req[s].store)
          || (s == 0 && te.wimg[0]);
      end else begin
        fin = 1'b0;
      end
    end

    always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
        st_reg <= S_IDLE;
        resp_reg <= '0;
      end else if (I_CE) begin
        unique case (st_reg)
          S_IDLE: if (s == 0 ? I_IVALID : I_DVALID) begin
            if (fin) begin
              resp_reg <= '{pa: pa, fault: flt, cset: pa[PA_SET_LSB +: 7]};
              st_reg <= S_RESP;
            end else begin
              st_reg <= S_WALK;
            end
          end
          S_WALK: if (w_st == W_DONE && w_side == 1'(s)) begin
            if (w_fault) begin
              resp_reg <= '{pa: req[s].ea, fault: 1'b1, cset: req[s].ea[PA_SET_LSB +: 7]};
              st_reg <= S_RESP;
            end else begin
              st_reg <= S_IDLE;
            end
          end
          S_RESP: st_reg <= S_IDLE;
          default: st_reg <= S_IDLE;
        endcase
      end
    end

    always_ff @(posedge I_REF_CLK) begin
      if (I_RESET) begin
        tv <= '{default: 2'h0};
        lru_reg <= '0;
      end else if (I_CE) begin
        if (fill) begin
          tv[fset][fway] <= 1'b1;
          tlb[fset][fway] <= '{tag: ftag, rpn: w_w1[31:12], r: w_w1[PTE_R], c: w_w1[PTE_C],
            wimg: w_w1[6:3], pp: w_w1[1:0]};
          lru_reg[fset] <= ~fway;
        end else if (st_reg == S_IDLE && fin && |wh && !bhit && en_bit(s)) begin
          lru_reg[set] <= wh[0];
        end
        if (inval) begin
          tv[I_PWDATA[17:12]] <= 2'h0;
        end
      end
    end
  end

  function automatic logic en_bit(input int sd);
    en_bit = sd == 0 ? ctrl_reg[CTRL_IEN] : ctrl_reg[CTRL_DEN];
  endfunction : en_bit

  assign O_IDONE = g_side[0].st_reg == S_RESP;
  assign O_IRESP = g_side[0].resp_reg;
  assign O_DDONE = g_side[1].st_reg == S_RESP;
  assign O_DRESP = g_side[1].resp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET || !I_CE);

  sequence s_pte_read;
    w_st == W_RD1 && I_MEM_ACK;
  endsequence
  sequence s_walk_ok;
    w_st == W_DONE && !w_fault && w_side && !inval;
  endsequence

  chk_real_mode: assert property (g_side[0].st_reg == S_IDLE && I_IVALID && !ctrl_reg[CTRL_IEN]
    |=> O_IDONE && !O_IRESP.fault && O_IRESP.pa == $past(I_IREQ.ea)) else $error("real mode pa wrong");
  chk_seg_copies: assert property (seg_copy[0] == seg_copy[1]) else $error("segment copies differ");
  chk_page_offset: assert property (O_DDONE && I_DVALID
    |-> O_DRESP.pa[11:0] == I_DREQ.ea[11:0]) else $error("page offset altered");
  chk_cache_set: assert property (O_IDONE |-> O_IRESP.cset == O_IRESP.pa[11:5]) else $error("set index wrong");
  chk_walk_start: assert property (w_st == W_IDLE && |walk_req
    |=> w_st == W_RD0 && w_idx == 3'h0 && !w_sec) else $error("search start wrong");
  chk_store_rc: assert property (s_pte_read ##0 w_store |=> w_w1[PTE_R] && w_w1[PTE_C]) else $error("rc not set");
  chk_rc_write: assert property (w_st == W_UPD |-> O_MEM_REQ && O_MEM.we && O_MEM.wdata[PTE_R])
    else $error("rc write wrong");
  chk_fill_hit: assert property (s_walk_ok |=> ##1 O_DDONE) else $error("fill did not hit");
  chk_nx_fetch: assert property (g_side[0].st_reg == S_IDLE && I_IVALID && ctrl_reg[CTRL_IEN]
    && !g_side[0].bhit && g_side[0].sg.nx |=> O_IDONE && O_IRESP.fault) else $error("nx fetch passed");
  chk_miss_fault: assert property (w_st == W_DONE && w_fault && w_side
    |=> O_DDONE && O_DRESP.fault) else $error("miss fault lost");
endmodule : address_translation_unit
`default_nettype wire

// File: rtl/atu_pkg.sv
// Shared constants and types of the address translation unit.
// Assumes one core clock; all users import the whole package.
package atu_pkg;
  // Register map (APB byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PTB = 8'h08;
  localparam logic [7:0] OFF_INVAL = 8'h0C;
  localparam logic [7:0] OFF_SYNC = 8'h10;
  localparam logic [1:0] REGION_SEG = 2'h1;
  localparam logic [1:0] REGION_INSTR_BLOCK_MAP_ENTRY = 2'h2;
  localparam logic [1:0] REGION_DATA_BLOCK_MAP_ENTRY = 2'h3;
  // Control and reset values
  localparam int CTRL_IEN = 0;
  localparam int CTRL_DEN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] PTB_RST = 32'h0;
  // Segment register fields
  localparam int SEG_NX = 28;
  localparam int SEG_KP = 29;
  localparam int SEG_KS = 30;
  // Block map fields
  localparam int BAT_EPI_LSB = 17;
  localparam int BAT_BL_LSB = 2;
  localparam int BAT_VS = 1;
  localparam int BAT_VP = 0;
  localparam int BAT_WIMG_LSB = 3;
  // Page table entry fields
  localparam int PTE_V = 31;
  localparam int PTE_H = 6;
  localparam logic [31:0] PTE_R_MASK = 32'h0000_0100;
  localparam logic [31:0] PTE_C_MASK = 32'h0000_0080;
  localparam int PTE_R = 8;
  localparam int PTE_C = 7;
  // Geometry
  localparam int SEG_N = 16;
  localparam int BAT_N = 8;
  localparam int TLB_SETS = 64;
  localparam int TLB_WAYS = 2;
  localparam int PA_SET_LSB = 5;
  typedef struct packed {logic [31:0] ea; logic user; logic store;} xreq_t;
  typedef struct packed {logic [31:0] pa; logic fault; logic [6:0] cset;} xresp_t;
  typedef struct packed {logic nx; logic ks; logic kp; logic [23:0] vsid;} seg_t;
  typedef struct packed {
    logic [33:0] tag; logic [19:0] rpn; logic r; logic c; logic [3:0] wimg; logic [1:0] pp;
  } tlb_ent_t;
  typedef struct packed {logic [31:0] addr; logic we; logic [31:0] wdata;} mreq_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_RESP = 2'h1, S_WALK = 2'h2} side_st_t;
  typedef enum logic [2:0] {
    W_IDLE = 3'h0, W_RD0 = 3'h1, W_RD1 = 3'h3, W_UPD = 3'h2, W_DONE = 3'h6
  } walk_st_t;
endpackage : atu_pkg
